// *** hdl/flash_host.sv ***
// host controller driving a parallel sector flash, commanded over axi4-lite
// Operation
// - keep sector address valid each falling strobe
// - output gate high while writing
// - next byte load within load window
// - lock command followed by full sector
// - polling reads keep address constant
// - commands decoded on A14..A0 only
// - locked part needs three-write unlock
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module flash_host
  import flash_host_pkg::*;
#(
  parameter int unsigned CYCLE_TIMEOUT = CYCLE_MAX_CYC,
  parameter int unsigned LOAD_WINDOW   = BLOAD_WIN_CYC,
  parameter logic [14:0] CMD_A1        = 15'h5555,
  parameter logic [14:0] CMD_A2        = 15'h2AAA,
  parameter logic [7:0]  CMD_D1        = 8'hAA,
  parameter logic [7:0]  CMD_D2        = 8'h55,
  parameter logic [7:0]  CMD_LOCK_ON   = 8'hA0,
  parameter logic [7:0]  CMD_LOCK_OFF1 = 8'h80,
  parameter logic [7:0]  CMD_LOCK_OFF2 = 8'h20,
  parameter logic [7:0]  CMD_ID_ENTER  = 8'h90,
  parameter logic [7:0]  CMD_ID_EXIT   = 8'hF0
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // axi4-lite write
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // axi4-lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // flash pins
  output logic             chip_sel_n,
  output logic             out_gate_n,
  output logic             wr_strobe_n,
  output logic [16:0]      flash_addr,
  output logic [7:0]       data_out,
  output logic             data_oe,
  input  wire logic [7:0]  data_in
);

  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_WSET  = 7'b0000010,
    S_WLOW  = 7'b0000100,
    S_WHIGH = 7'b0001000,
    S_RLOW  = 7'b0010000,
    S_RHIGH = 7'b0100000,
    S_WAIT  = 7'b1000000
  } state_e;

  // one step of a command prefix: address on A14..A0 and data
  function automatic logic [22:0] seq_step(input logic [2:0] op, input logic [2:0] idx);
    logic [7:0] d3;
    d3 = CMD_LOCK_ON;
    case (op)
      OP_LOCK_OFF: d3 = CMD_LOCK_OFF1;
      OP_ID_ENTER: d3 = CMD_ID_ENTER;
      OP_ID_EXIT:  d3 = CMD_ID_EXIT;
      default:     d3 = CMD_LOCK_ON;
    endcase
    case (idx)
      3'h0:    seq_step = {CMD_A1, CMD_D1};
      3'h1:    seq_step = {CMD_A2, CMD_D2};
      3'h2:    seq_step = {CMD_A1, d3};
      3'h3:    seq_step = {CMD_A1, CMD_D1};
      3'h4:    seq_step = {CMD_A2, CMD_D2};
      default: seq_step = {CMD_A1, CMD_LOCK_OFF2};
    endcase
  endfunction

  state_e      state_ff, nxt_state;
  logic [2:0]  op_ff, nxt_op, step_ff, nxt_step, nsteps_ff, nxt_nsteps;
  logic [7:0]  ph_ff, nxt_ph, wbyte_ff, rbyte_ff, prev_ff, nloaded_ff;
  logic [7:0]  din_m_ff, din_s_ff, awa_ff;
  logic [31:0] tmr_ff, nxt_tmr, wd_ff;
  logic [16:0] addr_ff;
  logic [3:0]  ws_ff;
  logic        unlk_ff, prev_ok_ff, got_ff, busy_ff, done_ff, tmo_ff, aw_ff, w_ff;

  // write channel: take address and data in either order
  wire         wr_go     = aw_ff && w_ff && !bvalid;
  wire         hit_ctrl  = wr_go && awa_ff == REG_CTRL;
  wire         hit_addr  = wr_go && awa_ff == REG_ADDR;
  wire         hit_wdat  = wr_go && awa_ff == REG_WDATA;
  wire         wr_known  = hit_ctrl || hit_addr || hit_wdat;
  wire         start     = hit_ctrl && !busy_ff && wd_ff[2:0] != OP_NONE;
  wire         in_prefix = step_ff < nsteps_ff;
  wire [22:0]  nxt_seq   = seq_step(nxt_op, nxt_step);
  wire         nxt_pre   = nxt_step < nxt_nsteps;
  wire [16:0]  nxt_addr  = nxt_pre ? {2'b00, nxt_seq[22:8]} : addr_ff;
  // a byte written in the load window must go out now, not on the next load
  wire [7:0]   wr_byte   = (hit_wdat && ws_ff[0]) ? wd_ff[7:0] : wbyte_ff;
  wire [7:0]   nxt_data  = nxt_pre ? nxt_seq[7:0] : wr_byte;
  wire         is_read   = op_ff == OP_READ || op_ff == OP_POLL;
  wire         wait_to   = tmr_ff >= LOAD_WINDOW - 1;
  // poll: two successive reads agree on bits 7 and 6
  wire         poll_done = prev_ok_ff && prev_ff[7:6] == rbyte_ff[7:6];

  wire [31:0]  status_w  = {16'h0000, nloaded_ff, 5'h00, tmo_ff, done_ff, busy_ff};
  wire [31:0]  rd_mux    = araddr == REG_CTRL   ? {28'h0000000, unlk_ff, op_ff} :
                           araddr == REG_ADDR   ? {15'h0000, addr_ff} :
                           araddr == REG_WDATA  ? {24'h000000, wbyte_ff} :
                           araddr == REG_STATUS ? status_w :
                           {24'h000000, rbyte_ff};
  wire         rd_known  = araddr == REG_CTRL || araddr == REG_ADDR ||
                           araddr == REG_WDATA || araddr == REG_STATUS ||
                           araddr == REG_RDATA;

  always_comb begin
    nxt_state  = state_ff;
    nxt_op     = op_ff;
    nxt_step   = step_ff;
    nxt_nsteps = nsteps_ff;
    nxt_ph     = ph_ff + 8'h01;
    nxt_tmr    = tmr_ff;
    case (state_ff)
      S_IDLE: begin
        nxt_ph = 8'h00;
        if (start) begin
          nxt_op   = wd_ff[2:0];
          nxt_step = 3'h0;
          case (wd_ff[2:0])
            OP_LOAD:     nxt_nsteps = wd_ff[CTRL_UNLK_BIT] ? 3'h3 : 3'h0;
            OP_LOCK_ON:  nxt_nsteps = 3'h3;
            OP_LOCK_OFF: nxt_nsteps = 3'h6;
            OP_ID_ENTER: nxt_nsteps = 3'h3;
            OP_ID_EXIT:  nxt_nsteps = 3'h3;
            default:     nxt_nsteps = 3'h0;
          endcase
          nxt_state = (wd_ff[2:0] == OP_READ || wd_ff[2:0] == OP_POLL) ? S_RLOW : S_WSET;
        end
      end
      S_WSET: begin
        nxt_state = S_WLOW;
        nxt_ph    = 8'h00;
      end
      S_WLOW: if (ph_ff >= WP_CYC - 8'h01) begin
        nxt_state = S_WHIGH;
        nxt_ph    = 8'h00;
      end
      S_WHIGH: if (ph_ff >= WPH_CYC - 8'h01) begin
        nxt_ph = 8'h00;
        if (in_prefix && step_ff + 3'h1 < nsteps_ff) begin
          nxt_step  = step_ff + 3'h1;
          nxt_state = S_WSET;
        end else if (in_prefix && (op_ff == OP_ID_ENTER || op_ff == OP_ID_EXIT)) begin
          nxt_state = S_IDLE;
        end else if (in_prefix) begin
          // lock commands continue straight into data loads
          nxt_step  = nsteps_ff;
          nxt_state = S_WSET;
        end else begin
          nxt_tmr   = 32'h0;
          nxt_state = S_WAIT;
        end
      end
      S_WAIT: begin
        // next byte must arrive inside the load window
        nxt_tmr = tmr_ff + 32'h1;
        nxt_ph  = 8'h00;
        if (hit_wdat && !wait_to) begin
          nxt_tmr   = 32'h0;
          nxt_state = S_WSET;
        end else if (wait_to && !hit_wdat) begin
          // window closed by the part itself; now poll its cycle
          nxt_op    = OP_POLL;
          nxt_tmr   = 32'h0;
          nxt_state = S_RLOW;
        end
      end
      S_RLOW: begin
        if (op_ff == OP_POLL) nxt_tmr = tmr_ff + 32'h1;
        if (ph_ff >= ACC_CYC - 8'h01) begin
          nxt_state = S_RHIGH;
          nxt_ph    = 8'h00;
        end
      end
      S_RHIGH: begin
        if (op_ff == OP_POLL) nxt_tmr = tmr_ff + 32'h1;
        if (ph_ff >= WPH_CYC - 8'h01) begin
          nxt_ph    = 8'h00;
          nxt_state = (op_ff == OP_POLL && !poll_done && tmr_ff < CYCLE_TIMEOUT)
                      ? S_RLOW : S_IDLE;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff  <= S_IDLE;
      op_ff     <= OP_NONE;
      step_ff   <= 3'h0;
      nsteps_ff <= 3'h0;
      ph_ff     <= 8'h00;
      tmr_ff    <= 32'h0;
    end else begin
      state_ff  <= nxt_state;
      op_ff     <= nxt_op;
      step_ff   <= nxt_step;
      nsteps_ff <= nxt_nsteps;
      ph_ff     <= nxt_ph;
      tmr_ff    <= nxt_tmr;
    end
  end

  // data pins are asynchronous to us
  always_ff @(posedge clock) begin
    if (srst) begin
      din_m_ff <= 8'h00;
      din_s_ff <= 8'h00;
    end else begin
      din_m_ff <= data_in;
      din_s_ff <= din_m_ff;
    end
  end

  // pin drivers; gate stays high for every write phase
  always_ff @(posedge clock) begin
    if (srst) begin
      chip_sel_n  <= 1'b1;
      out_gate_n  <= 1'b1;
      wr_strobe_n <= 1'b1;
      flash_addr  <= 17'h00000;
      data_out    <= 8'h00;
      data_oe     <= 1'b0;
    end else begin
      chip_sel_n  <= !(nxt_state == S_WLOW || nxt_state == S_RLOW || nxt_state == S_WSET);
      out_gate_n  <= nxt_state != S_RLOW;
      wr_strobe_n <= nxt_state != S_WLOW;
      data_oe     <= nxt_state == S_WSET || nxt_state == S_WLOW;
      if (nxt_state == S_WSET) begin
        flash_addr <= nxt_addr;
        data_out   <= nxt_data;
      end else if (state_ff == S_IDLE && nxt_state == S_RLOW) begin
        flash_addr <= addr_ff;
      end
    end
  end

  // status, captured read data, software registers
  always_ff @(posedge clock) begin
    if (srst) begin
      addr_ff    <= 17'h00000;
      wbyte_ff   <= 8'h00;
      unlk_ff    <= 1'b0;
      rbyte_ff   <= 8'h00;
      prev_ff    <= 8'h00;
      prev_ok_ff <= 1'b0;
      got_ff     <= 1'b0;
      nloaded_ff <= 8'h00;
      busy_ff    <= 1'b0;
      done_ff    <= 1'b0;
      tmo_ff     <= 1'b0;
    end else begin
      if (hit_addr && ws_ff[0]) addr_ff[7:0] <= wd_ff[7:0];
      if (hit_addr && ws_ff[1]) addr_ff[15:8] <= wd_ff[15:8];
      if (hit_addr && ws_ff[2]) addr_ff[16] <= wd_ff[16];
      // low seven address bits step the byte within the sector
      if (state_ff == S_WHIGH && nxt_state == S_WAIT && !in_prefix)
        addr_ff[6:0] <= addr_ff[6:0] + 7'h01;
      wbyte_ff <= wr_byte;
      if (start) unlk_ff <= wd_ff[CTRL_UNLK_BIT];
      busy_ff <= nxt_state != S_IDLE;
      if (start) begin
        done_ff    <= 1'b0;
        tmo_ff     <= 1'b0;
        nloaded_ff <= 8'h00;
        prev_ok_ff <= 1'b0;
        got_ff     <= 1'b0;
      end else if (state_ff != S_IDLE && nxt_state == S_IDLE) begin
        done_ff <= 1'b1;
        tmo_ff  <= op_ff == OP_POLL && !poll_done;
      end
      if (state_ff == S_WHIGH && nxt_state == S_WAIT && !in_prefix && nloaded_ff < 8'hFF)
        nloaded_ff <= nloaded_ff + 8'h01;
      // sample before the gate rises; a released bus carries nothing
      if (state_ff == S_RLOW && nxt_state == S_RHIGH) begin
        rbyte_ff   <= din_s_ff;
        prev_ff    <= rbyte_ff;
        prev_ok_ff <= got_ff;
        got_ff     <= 1'b1;
      end
    end
  end

  // axi4-lite slave
  always_ff @(posedge clock) begin
    if (srst) begin
      aw_ff   <= 1'b0;
      w_ff    <= 1'b0;
      awa_ff  <= 8'h00;
      wd_ff   <= 32'h0;
      ws_ff   <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else begin
      awready <= !aw_ff && !awready && awvalid && !bvalid;
      wready  <= !w_ff && !wready && wvalid && !bvalid;
      if (awvalid && awready) begin
        aw_ff  <= 1'b1;
        awa_ff <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_ff  <= 1'b1;
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end
      if (wr_go) begin
        aw_ff  <= 1'b0;
        w_ff   <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      arready <= !arready && arvalid && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_mux;
        rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

// *** hdl/flash_host_pkg.sv ***
// constants for the parallel flash host controller
package flash_host_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned BLOAD_WIN_US   = 150;
  localparam int unsigned CYCLE_MAX_MS   = 10;
  // longest window, an exact cycle count; host stops waiting for a byte one cycle short of it
  localparam int unsigned BLOAD_WIN_CYC  = BLOAD_WIN_US * CLK_MHZ;
  localparam int unsigned CYCLE_MAX_CYC  = CYCLE_MAX_MS * 1000 * CLK_MHZ;
  // phase lengths in clock cycles, rounded up (write pulse low, pulse high, read access)
  localparam int unsigned WP_NS          = 90;
  localparam int unsigned WPH_NS         = 100;
  localparam int unsigned ACC_NS         = 200;
  localparam int unsigned CLK_NS         = 4;
  localparam logic [7:0]  WP_CYC         = 8'((WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  WPH_CYC        = 8'((WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  ACC_CYC        = 8'((ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned SECTOR_BYTES   = 128;
  // register byte offsets
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_ADDR       = 8'h04;
  localparam logic [7:0]  REG_WDATA      = 8'h08;
  localparam logic [7:0]  REG_STATUS     = 8'h0C;
  localparam logic [7:0]  REG_RDATA      = 8'h10;
  // ctrl opcodes (bits 2:0)
  localparam logic [2:0]  OP_NONE        = 3'h0;
  localparam logic [2:0]  OP_LOAD        = 3'h1;
  localparam logic [2:0]  OP_READ        = 3'h2;
  localparam logic [2:0]  OP_LOCK_ON     = 3'h3;
  localparam logic [2:0]  OP_LOCK_OFF    = 3'h4;
  localparam logic [2:0]  OP_ID_ENTER    = 3'h5;
  localparam logic [2:0]  OP_ID_EXIT     = 3'h6;
  localparam logic [2:0]  OP_POLL        = 3'h7;
  localparam int unsigned CTRL_UNLK_BIT  = 3;
  // status bits
  localparam int unsigned ST_BUSY        = 0;
  localparam int unsigned ST_DONE        = 1;
  localparam int unsigned ST_TIMEOUT     = 2;
  localparam int unsigned ST_CNT_LSB     = 8;
  // bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage

// *** test/flash_host_monitor.sv ***
// assertion checker for the flash host controller bus and flash pins
`timescale 1ns/1ns
module flash_host_monitor
  import flash_host_pkg::*;
#(
  parameter int unsigned CYCLE_TIMEOUT = CYCLE_MAX_CYC,
  parameter int unsigned LOAD_WINDOW   = BLOAD_WIN_CYC
) (
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // axi4-lite
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [7:0]  awaddr,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // flash pins
  input wire logic        chip_sel_n,
  input wire logic        out_gate_n,
  input wire logic        wr_strobe_n,
  input wire logic [16:0] flash_addr,
  input wire logic        data_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic [7:0] wlo_ff;
  logic [7:0] rlo_ff;
  logic [7:0] awa_ff;
  wire        map_ok = awa_ff inside {REG_CTRL, REG_ADDR, REG_WDATA, REG_STATUS, REG_RDATA};
  // pulse lengths counted here so widths can be checked past the repetition limit
  always_ff @(posedge clock) begin
    wlo_ff <= wr_strobe_n ? 8'h00 : wlo_ff + 8'h01;
    rlo_ff <= out_gate_n ? 8'h00 : rlo_ff + 8'h01;
    if (awvalid && awready) awa_ff <= awaddr;
  end
  sequence s_wr_end;
    $rose(wr_strobe_n);
  endsequence
  sequence s_rd_end;
    $rose(out_gate_n);
  endsequence
  sequence s_ar_taken;
    arvalid && arready;
  endsequence
  property p_idle_after_reset;
    @(posedge clock) disable iff (1'b0) srst |=> chip_sel_n && wr_strobe_n && out_gate_n && !data_oe;
  endproperty
  AST_OE_HIGH_WRITE: assert property (!wr_strobe_n && !chip_sel_n |-> out_gate_n && data_oe)
    else $error("output gate low or data undriven during write");
  AST_ADDR_HOLD_WRITE: assert property (!wr_strobe_n && $past(!wr_strobe_n) |-> $stable(flash_addr))
    else $error("address moved within write pulse");
  AST_WRITE_WIDTH: assert property (s_wr_end |-> wlo_ff >= WP_CYC)
    else $error("write pulse too short");
  AST_READ_WIDTH: assert property (s_rd_end |-> rlo_ff >= ACC_CYC)
    else $error("read pulse too short");
  AST_ADDR_HOLD_READ: assert property (!out_gate_n && $past(!out_gate_n) |-> $stable(flash_addr))
    else $error("address moved within read pulse");
  AST_NO_DRIVE_READ: assert property (!out_gate_n |-> !data_oe && wr_strobe_n && !chip_sel_n)
    else $error("data driven or strobe low during read");
  AST_BRESP_MAP: assert property ($rose(bvalid) |-> bresp == (map_ok ? RESP_OKAY : RESP_SLVERR))
    else $error("write response code wrong");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_R_ANSWER: assert property (s_ar_taken |=> rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  AST_RESET_IDLE: assert property (p_idle_after_reset)
    else $error("flash pins not idle after reset");
endmodule

bind flash_host flash_host_monitor #(.CYCLE_TIMEOUT(CYCLE_TIMEOUT), .LOAD_WINDOW(LOAD_WINDOW)) i_mon (
  .clock(clock), .srst(srst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .chip_sel_n(chip_sel_n),
  .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n), .flash_addr(flash_addr), .data_oe(data_oe));

// *** test/flash_sector_model.sv ***
// behavioural sector flash answering the host controller
`timescale 1ns/1ns
module flash_sector_model #(
  parameter int unsigned LOAD_WINDOW = 190,
  parameter int unsigned CYCLE_TIME  = 600,
  parameter logic [7:0]  MAKER_CODE  = 8'h3C,  // arbitrary value
  parameter logic [7:0]  PART_CODE   = 8'h6B   // arbitrary value
) (
  // host pins
  input  wire logic        clock,
  input  wire logic        chip_sel_n,
  input  wire logic        out_gate_n,
  input  wire logic        wr_strobe_n,
  input  wire logic [16:0] flash_addr,
  input  wire logic [7:0]  data_out,
  // data back to host
  output logic      [7:0]  data_in
);
  logic [7:0]   mem [0:131071];
  logic [7:0]   pbuf [0:127];
  logic [127:0] pval = '0;
  logic [16:0]  la;
  logic [7:0]   ld = 8'h00;
  logic [7:0]   rv;
  logic [7:0]   last = 8'h00;
  logic [9:0]   sec;
  logic         wr_q = 1'b0, rd_q = 1'b0, busy = 1'b0, tog = 1'b0, armed = 1'b0;
  logic         idm = 1'b0, lock = 1'b0, lk_on = 1'b0, lk_off = 1'b0, unlk = 1'b0;
  logic         hit;
  int           step = 0;
  int           tmr = 0;
  wire          wr = !chip_sel_n && !wr_strobe_n && out_gate_n;
  wire          rd = !chip_sel_n && !out_gate_n && wr_strobe_n;
  assign rv = idm ? (flash_addr[0] ? PART_CODE : MAKER_CODE)
            : busy ? {~ld[7], tog, ld[5:0]} : mem[flash_addr];
  // a released bus must not look like the last byte
  assign data_in = rd ? rv : ~last;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // only the low fifteen address bits take part in command matching
  task automatic take(input logic [16:0] a, input logic [7:0] d);
    if (step == 0 || step == 3) hit = (a[14:0] == 15'h5555 && d == 8'hAA);
    else if (step == 1 || step == 4) hit = (a[14:0] == 15'h2AAA && d == 8'h55);
    else hit = (a[14:0] == 15'h5555) && (step == 2 ? d inside {8'hA0, 8'h80, 8'h90, 8'hF0} : d == 8'h20);
    if (hit && step == 2 && d == 8'hA0) {lk_on, unlk} = 2'b11;
    if (hit && step == 2 && d == 8'h90) idm = 1'b1;
    if (hit && step == 2 && d == 8'hF0) idm = 1'b0;
    if (hit && step == 5) {lk_off, unlk} = 2'b11;
    step = (!hit || step == 5 || (step == 2 && d != 8'h80)) ? 0 : step + 1;
    if (!hit && !idm) begin
      pbuf[a[6:0]] = d;
      pval[a[6:0]] = 1'b1;
      sec = a[16:7];
      ld = d;
      armed = 1'b1;
    end
  endtask
  always @(posedge clock) begin
    if (rd) last = rv;
    if (wr && !wr_q) la = flash_addr;
    if (!wr && wr_q && !busy) take(la, data_out);
    if (rd && !rd_q && busy) tog = !tog;
    tmr = (wr && !busy) ? 0 : tmr + 1;
    if (armed && !busy && tmr >= LOAD_WINDOW) begin
      armed = 1'b0;
      busy = 1'b1;
      tmr = 0;
    end
    if (busy && tmr >= CYCLE_TIME) begin
      busy = 1'b0;
      if (!lock || unlk) for (int i = 0; i < 128; i++) mem[{sec, i[6:0]}] = pval[i] ? pbuf[i] : 8'hFF;
      lock = lk_on ? 1'b1 : (lk_off ? 1'b0 : lock);
      {lk_on, lk_off, unlk, pval} = '0;
      step = 0;
    end
    wr_q = wr;
    rd_q = rd;
  end
endmodule

// *** test/test_flash_host.sv ***
// self-checking bench for the flash host controller
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_flash_host;
  import flash_host_pkg::*;
  localparam int unsigned LWIN = 200;
  logic        clock = 1'b0, srst = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, data_out, data_in;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic        awready, wready, bvalid, arready, rvalid, chip_sel_n, out_gate_n, wr_strobe_n, data_oe;
  logic [1:0]  bresp, rresp, rsp;
  logic [16:0] flash_addr;
  int          mismatches = 0, checks = 0;
  always #2 clock = ~clock;
  flash_host #(.CYCLE_TIMEOUT(2000), .LOAD_WINDOW(LWIN)) i_dut (
    .clock(clock), .srst(srst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .chip_sel_n(chip_sel_n),
    .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n), .flash_addr(flash_addr),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  flash_sector_model #(.LOAD_WINDOW(LWIN - 10)) i_flash (
    .clock(clock), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n),
    .flash_addr(flash_addr), .data_out(data_out), .data_in(data_in));
  task automatic end_of_test();
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_st(input logic want_done, input logic [7:0] cnt);
    int n;
    n = 0;
    do begin
      rd(REG_STATUS);
      n++;
    end while ((want_done ? rd_v[ST_DONE] !== 1'b1 : rd_v[15:8] !== cnt) && n < 3000);
    // a status that never arrives ends the run as a failure
    if (want_done ? rd_v[ST_DONE] !== 1'b1 : rd_v[15:8] !== cnt) begin
      mismatches++;
      end_of_test();
    end
  endtask
  // bytes carry the low address byte so any location's content is predictable
  task automatic load(input logic [3:0] ctl, input logic [16:0] base, input int n);
    wr(REG_WDATA, {24'h0, base[7:0]});
    wr(REG_ADDR, {15'h0, base});
    wr(REG_CTRL, {28'h0, ctl});
    for (int i = 1; i < n; i++) begin
      wait_st(1'b0, 8'(i));
      repeat (50) @(posedge clock);
      wr(REG_WDATA, {24'h0, 8'(base[7:0] + i)});
    end
    wait_st(1'b1, 8'h00);
    `CHK("timeout", 1'b0, rd_v[ST_TIMEOUT])
  endtask
  task automatic fread(input logic [16:0] a, input logic [7:0] ex);
    wr(REG_ADDR, {15'h0, a});
    wr(REG_CTRL, {29'h0, OP_READ});
    wait_st(1'b1, 8'h00);
    rd(REG_RDATA);
    `CHK("flash byte", ex, rd_v[7:0])
  endtask
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(REG_STATUS);
    `CHK("status", 32'h0, rd_v)
    wr(8'h40, 32'h1);
    `CHK("bresp", RESP_SLVERR, rsp)
    rd(8'h44);
    `CHK("rresp", RESP_SLVERR, rsp)
    load(4'h1, 17'h00080, 2);
    fread(17'h00080, 8'h80);
    fread(17'h00081, 8'h81);
    fread(17'h00082, 8'hFF);
    load({1'b0, OP_LOCK_ON}, 17'h00100, 128);
    fread(17'h0017F, 8'h7F);
    load(4'h1, 17'h00205, 1);
    fread(17'h00205, 8'h00);
    load(4'h9, 17'h00205, 1);
    fread(17'h00205, 8'h05);
    load({1'b0, OP_LOCK_OFF}, 17'h00300, 128);
    load(4'h1, 17'h00405, 1);
    fread(17'h00405, 8'h05);
    wr(REG_CTRL, {29'h0, OP_ID_ENTER});
    wait_st(1'b1, 8'h00);
    fread(17'h00000, 8'h3C);
    fread(17'h00001, 8'h6B);
    wr(REG_CTRL, {29'h0, OP_ID_EXIT});
    wait_st(1'b1, 8'h00);
    fread(17'h00080, 8'h80);
    end_of_test();
  end
  initial begin
    repeat (95000) @(posedge clock);
    mismatches++;
    end_of_test();
  end
endmodule
